// ===== include/led_pkg.sv
// Constants for the status lamp pattern driver.
// Assumes a 100 MHz system clock.
package led_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   // Timebase tick of 1 ms
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYC = (TICK_MS * 1_000_000) / CLK_PERIOD_NS;
   // Pattern phase times in ms
   localparam int unsigned FLICKER_MS = 50;
   localparam int unsigned BLINK_MS = 200;
   // Pause closing a double blink, chosen
   localparam int unsigned PAUSE_MS = 1000;
   // Field supply fault may be reported this late
   localparam int unsigned PDS_DELAY_MS = 15;
   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COND = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   // Control bit positions
   localparam int unsigned C_POWER = 0;
   localparam int unsigned C_FAILED = 1;
   localparam int unsigned C_ADDRESSING = 2;
   localparam int unsigned C_WDOG = 3;
   localparam int unsigned C_TESTED = 4;
   localparam int unsigned C_OPER = 5;
   localparam int unsigned C_OVERCUR = 6;
   localparam int unsigned C_BROKEN = 7;
   localparam int unsigned C_NOFIELD = 8;
   localparam int unsigned C_PDS_SHORT = 9;
   localparam int unsigned C_PREOP = 10;
   localparam int unsigned C_NONFATAL = 11;
   localparam int unsigned C_BUS_STOP = 12;
   localparam int unsigned C_NUM = 13;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam int unsigned IRQ_NUM = 4;
   // Interrupt event bits
   localparam int unsigned I_WDOG = 0;
   localparam int unsigned I_FAULT = 1;
   localparam int unsigned I_NONFATAL = 2;
   localparam int unsigned I_BUS_STOP = 3;
   typedef enum logic [2:0] {PAT_OFF, PAT_ON, PAT_FLICKER, PAT_BLINK1, PAT_BLINK2} pattern_t;
endpackage

// ===== rtl/status_led_pattern_driver.sv
// Front-panel ready and fault lamp driver with APB control and status.
// Assumes software mirrors module conditions into the control register.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
// How it works
// - Both lamps dark without power or failed
// - Addressing: ready flickers, fault off
// - Watchdog timeout: both lamps steady, latched
// - Operational and tested: ready on, fault off
// - Over-current: ready on, fault flickers
// - Broken wire: fault flickers
// - No field power: fault flickers
// - Field supply short: fault flickers
// - Pre-operational: ready single blink
// - Nonfatal error: fault blink, latched
// - Island bus stopped: fault double blink
// - Flicker is 50 ms on, 50 off
// - Single blink is 200 ms on, 200 off
// - Double blink: on, off, on, pause
// - Supply fault shown within 15 ms
// - Local field faults shown at once
module status_led_pattern_driver #(
   parameter int unsigned TICK_CYC = led_pkg::TICK_CYC
) (
   // System
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Lamps and interrupt
   output logic ready_led_o,
   output logic fault_led_o,
   output logic irq_o
);
   logic [31:0] ctrl_ff;
   logic [31:0] prdata_ff;
   logic [led_pkg::IRQ_NUM-1:0] irq_stat_ff;
   logic [led_pkg::IRQ_NUM-1:0] irq_mask_ff;
   logic wdog_lat_ff;
   logic nonfatal_lat_ff;
   localparam int unsigned TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   logic [TW-1:0] tick_cnt_ff;
   logic tick_ff;
   logic ready_led_ff;
   logic fault_led_ff;
   led_pkg::pattern_t rdy_pat_ff;
   led_pkg::pattern_t flt_pat_ff;
   logic [11:0] rdy_ms_ff;
   logic [11:0] flt_ms_ff;
   logic [led_pkg::IRQ_NUM-1:0] ev_prev_ff;

   // Bus decode
   wire wr_en = psel_i & penable_i & pwrite_i;
   // Read data is captured in the setup cycle so it stands at the access edge
   wire rd_en = psel_i & ~penable_i & ~pwrite_i;
   wire hit_ctrl = paddr_i == led_pkg::ADDR_CTRL;
   wire hit_cond = paddr_i == led_pkg::ADDR_COND;
   wire hit_stat = paddr_i == led_pkg::ADDR_STAT;
   wire hit_irq = paddr_i == led_pkg::ADDR_IRQ;
   wire hit_mask = paddr_i == led_pkg::ADDR_MASK;
   wire hit_any = hit_ctrl | hit_cond | hit_stat | hit_irq | hit_mask;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit_any;
   assign prdata_o = prdata_ff;

   // Condition inputs
   wire powered = ctrl_ff[led_pkg::C_POWER] & ~ctrl_ff[led_pkg::C_FAILED];
   wire wdog_req = ctrl_ff[led_pkg::C_WDOG];
   wire errors_fault = ctrl_ff[led_pkg::C_OVERCUR] | ctrl_ff[led_pkg::C_BROKEN]
      | ctrl_ff[led_pkg::C_NOFIELD] | ctrl_ff[led_pkg::C_PDS_SHORT];
   wire [led_pkg::IRQ_NUM-1:0] ev_now = {ctrl_ff[led_pkg::C_BUS_STOP], nonfatal_lat_ff,
      errors_fault, wdog_lat_ff};
   wire [led_pkg::IRQ_NUM-1:0] ev_rise = ev_now & ~ev_prev_ff;

   // Per-lamp pattern choice, highest priority first
   led_pkg::pattern_t nxt_rdy_pat;
   led_pkg::pattern_t nxt_flt_pat;
   always_comb begin
      nxt_rdy_pat = led_pkg::PAT_OFF;
      nxt_flt_pat = led_pkg::PAT_OFF;
      if (!powered) begin
         nxt_rdy_pat = led_pkg::PAT_OFF;
         nxt_flt_pat = led_pkg::PAT_OFF;
      end else if (wdog_lat_ff) begin
         nxt_rdy_pat = led_pkg::PAT_ON;
         nxt_flt_pat = led_pkg::PAT_ON;
      end else begin
         // Fault lamp: errors before the stopped bus
         if (errors_fault)
            nxt_flt_pat = led_pkg::PAT_FLICKER;
         else if (nonfatal_lat_ff)
            nxt_flt_pat = led_pkg::PAT_BLINK1;
         else if (ctrl_ff[led_pkg::C_BUS_STOP])
            nxt_flt_pat = led_pkg::PAT_BLINK2;
         // Ready lamp: over-current holds it on, then modes
         if (ctrl_ff[led_pkg::C_OVERCUR])
            nxt_rdy_pat = led_pkg::PAT_ON;
         else if (ctrl_ff[led_pkg::C_ADDRESSING]) begin
            nxt_rdy_pat = led_pkg::PAT_FLICKER;
            nxt_flt_pat = led_pkg::PAT_OFF;
         end else if (ctrl_ff[led_pkg::C_PREOP])
            nxt_rdy_pat = led_pkg::PAT_BLINK1;
         else if (ctrl_ff[led_pkg::C_TESTED] & ctrl_ff[led_pkg::C_OPER])
            nxt_rdy_pat = led_pkg::PAT_ON;
      end
   end

   // Lamp level for a pattern at a ms position in its cycle
   function automatic logic pat_level(led_pkg::pattern_t p, logic [11:0] ms);
      logic lvl;
      lvl = 1'b0;
      unique case (p)
         led_pkg::PAT_OFF: lvl = 1'b0;
         led_pkg::PAT_ON: lvl = 1'b1;
         led_pkg::PAT_FLICKER: lvl = ms < 12'(led_pkg::FLICKER_MS);
         led_pkg::PAT_BLINK1: lvl = ms < 12'(led_pkg::BLINK_MS);
         led_pkg::PAT_BLINK2: lvl = (ms < 12'(led_pkg::BLINK_MS))
            || (ms >= 12'(2 * led_pkg::BLINK_MS) && ms < 12'(3 * led_pkg::BLINK_MS));
      endcase
      return lvl;
   endfunction

   // Cycle length in ms of a pattern
   function automatic logic [11:0] pat_len(led_pkg::pattern_t p);
      logic [11:0] len;
      len = 12'h001;
      unique case (p)
         led_pkg::PAT_OFF, led_pkg::PAT_ON: len = 12'h001;
         led_pkg::PAT_FLICKER: len = 12'(2 * led_pkg::FLICKER_MS);
         led_pkg::PAT_BLINK1: len = 12'(2 * led_pkg::BLINK_MS);
         led_pkg::PAT_BLINK2: len = 12'(3 * led_pkg::BLINK_MS + led_pkg::PAUSE_MS);
      endcase
      return len;
   endfunction

   // Millisecond position counter: restart on pattern change
   function automatic logic [11:0] ms_next(led_pkg::pattern_t cur, led_pkg::pattern_t nxt,
         logic [11:0] ms, logic tick);
      logic [11:0] r;
      r = ms;
      if (cur != nxt)
         r = 12'h000;
      else if (tick)
         r = (ms + 12'h001 >= pat_len(cur)) ? 12'h000 : ms + 12'h001;
      return r;
   endfunction

   wire [11:0] nxt_rdy_ms = ms_next(rdy_pat_ff, nxt_rdy_pat, rdy_ms_ff, tick_ff);
   wire [11:0] nxt_flt_ms = ms_next(flt_pat_ff, nxt_flt_pat, flt_ms_ff, tick_ff);
   wire nxt_ready_led = pat_level(nxt_rdy_pat, nxt_rdy_ms);
   wire nxt_fault_led = pat_level(nxt_flt_pat, nxt_flt_ms);
   wire tick_wrap = tick_cnt_ff == TW'(TICK_CYC - 1);

   logic [31:0] nxt_prdata;
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (rd_en && hit_ctrl)
         nxt_prdata = ctrl_ff;
      else if (rd_en && hit_cond)
         nxt_prdata = {30'h0000_0000, fault_led_ff, ready_led_ff};
      else if (rd_en && hit_stat)
         nxt_prdata = {24'h00_0000, 1'b0, flt_pat_ff, 1'b0, rdy_pat_ff} | {16'h0000, 14'h0000,
            nonfatal_lat_ff, wdog_lat_ff} << 16;
      else if (rd_en && hit_irq)
         nxt_prdata = {28'h000_0000, irq_stat_ff};
      else if (rd_en && hit_mask)
         nxt_prdata = {28'h000_0000, irq_mask_ff};
   end

   // Timebase: 1 ms tick
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= tick_wrap ? TW'(0) : tick_cnt_ff + TW'(1);
         tick_ff <= tick_wrap;
      end
   end

   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ctrl_ff <= led_pkg::CTRL_RST;
         irq_mask_ff <= '0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         if (wr_en && hit_ctrl)
            ctrl_ff <= pwdata_i;
         if (wr_en && hit_mask)
            irq_mask_ff <= pwdata_i[led_pkg::IRQ_NUM-1:0];
         prdata_ff <= nxt_prdata;
      end
   end

   // Latched conditions clear only on power loss or reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wdog_lat_ff <= 1'b0;
         nonfatal_lat_ff <= 1'b0;
      end else if (!ctrl_ff[led_pkg::C_POWER]) begin
         wdog_lat_ff <= 1'b0;
         nonfatal_lat_ff <= 1'b0;
      end else begin
         wdog_lat_ff <= wdog_lat_ff | wdog_req;
         nonfatal_lat_ff <= nonfatal_lat_ff | ctrl_ff[led_pkg::C_NONFATAL];
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_stat_ff <= '0;
         ev_prev_ff <= '0;
      end else begin
         ev_prev_ff <= ev_now;
         irq_stat_ff <= (irq_stat_ff & ~((wr_en && hit_irq) ? pwdata_i[led_pkg::IRQ_NUM-1:0] : '0))
            | ev_rise;
      end
   end
   assign irq_o = |(irq_stat_ff & irq_mask_ff);

   // Lamp pattern state
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rdy_pat_ff <= led_pkg::PAT_OFF;
         flt_pat_ff <= led_pkg::PAT_OFF;
         rdy_ms_ff <= 12'h000;
         flt_ms_ff <= 12'h000;
         ready_led_ff <= 1'b0;
         fault_led_ff <= 1'b0;
      end else begin
         rdy_pat_ff <= nxt_rdy_pat;
         flt_pat_ff <= nxt_flt_pat;
         rdy_ms_ff <= nxt_rdy_ms;
         flt_ms_ff <= nxt_flt_ms;
         ready_led_ff <= nxt_ready_led;
         fault_led_ff <= nxt_fault_led;
      end
   end
   assign ready_led_o = ready_led_ff;
   assign fault_led_o = fault_led_ff;

   // Local faults are shown one cycle after the control write, far within 15 ms

   // Lamp level follows the condition registers one clock later

   a_dark_unpowered: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !ctrl_ff[led_pkg::C_POWER] |=> (!ready_led_o && !fault_led_o))
      else $error("lamp lit without power");

   a_unpowered_pattern: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !powered |=> (rdy_pat_ff == led_pkg::PAT_OFF && flt_pat_ff == led_pkg::PAT_OFF))
      else $error("pattern held without power");

   a_wdog_both_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && wdog_lat_ff) |=> (ready_led_o && fault_led_o))
      else $error("watchdog lamps not steady");

   a_wdog_latched: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (wdog_lat_ff && ctrl_ff[led_pkg::C_POWER]) |=> wdog_lat_ff)
      else $error("watchdog latch dropped");

   a_wdog_sets_latch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (ctrl_ff[led_pkg::C_POWER] && wdog_req) |=> wdog_lat_ff)
      else $error("watchdog latch not set");

   a_addr_fault_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && !ctrl_ff[led_pkg::C_OVERCUR] && ctrl_ff[led_pkg::C_ADDRESSING])
      |=> !fault_led_o)
      else $error("fault lamp lit while addressing");

   a_addr_ready_flicker: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && !ctrl_ff[led_pkg::C_OVERCUR] && ctrl_ff[led_pkg::C_ADDRESSING])
      |-> nxt_rdy_pat == led_pkg::PAT_FLICKER)
      else $error("ready lamp not flickering while addressing");

   a_oper_ready_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (nxt_rdy_pat == led_pkg::PAT_ON) |=> ready_led_o)
      else $error("ready lamp not on");

   a_oper_fault_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && !errors_fault && !nonfatal_lat_ff && !ctrl_ff[led_pkg::C_BUS_STOP])
      |-> nxt_flt_pat == led_pkg::PAT_OFF)
      else $error("fault lamp lit with no fault");

   // Error indications

   a_overcur_ready_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && ctrl_ff[led_pkg::C_OVERCUR]) |=> ready_led_o)
      else $error("ready lamp dark on over-current");

   a_fault_flicker: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && errors_fault
      && (!ctrl_ff[led_pkg::C_ADDRESSING] || ctrl_ff[led_pkg::C_OVERCUR]))
      |-> nxt_flt_pat == led_pkg::PAT_FLICKER)
      else $error("fault lamp not flickering on error");

   a_field_fault_fast: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ($rose(errors_fault) && powered && !wdog_lat_ff && !ctrl_ff[led_pkg::C_ADDRESSING])
      |=> fault_led_o)
      else $error("field fault shown late");

   a_nonfatal_blink: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && !errors_fault && nonfatal_lat_ff && !ctrl_ff[led_pkg::C_ADDRESSING])
      |-> nxt_flt_pat == led_pkg::PAT_BLINK1)
      else $error("fault lamp not blinking on nonfatal error");

   a_nonfatal_latched: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (nonfatal_lat_ff && ctrl_ff[led_pkg::C_POWER]) |=> nonfatal_lat_ff)
      else $error("nonfatal latch dropped");

   // Mode indications

   a_preop_blink: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && !ctrl_ff[led_pkg::C_OVERCUR] && !ctrl_ff[led_pkg::C_ADDRESSING]
      && ctrl_ff[led_pkg::C_PREOP]) |-> nxt_rdy_pat == led_pkg::PAT_BLINK1)
      else $error("ready lamp not blinking in pre-operational mode");

   a_bus_stop_blink: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (powered && !wdog_lat_ff && !errors_fault && !nonfatal_lat_ff && !ctrl_ff[led_pkg::C_ADDRESSING]
      && ctrl_ff[led_pkg::C_BUS_STOP]) |-> nxt_flt_pat == led_pkg::PAT_BLINK2)
      else $error("fault lamp not double blinking");

   // Pattern timing
   a_flicker_restart: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (nxt_flt_pat != flt_pat_ff && nxt_flt_pat == led_pkg::PAT_FLICKER) |=> fault_led_o)
      else $error("pattern did not start on");
   a_blink_phase: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (rdy_pat_ff == led_pkg::PAT_BLINK1 && rdy_ms_ff == 12'(led_pkg::BLINK_MS)) |-> !ready_led_o
      || $changed(rdy_pat_ff))
      else $error("single blink off phase wrong");

   a_flicker_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (flt_pat_ff == led_pkg::PAT_FLICKER) |-> flt_ms_ff < 12'(2 * led_pkg::FLICKER_MS))
      else $error("flicker cycle too long");

   a_flicker_off_phase: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (flt_pat_ff == led_pkg::PAT_FLICKER && flt_ms_ff >= 12'(led_pkg::FLICKER_MS)) |-> !fault_led_o)
      else $error("flicker off phase lit");

   a_blink_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (rdy_pat_ff == led_pkg::PAT_BLINK1) |-> rdy_ms_ff < 12'(2 * led_pkg::BLINK_MS))
      else $error("single blink cycle too long");

   a_dbl_pause: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (flt_pat_ff == led_pkg::PAT_BLINK2 && flt_ms_ff >= 12'(3 * led_pkg::BLINK_MS)) |-> !fault_led_o)
      else $error("double blink pause lit");
   a_dbl_second_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (flt_pat_ff == led_pkg::PAT_BLINK2 && nxt_flt_pat == led_pkg::PAT_BLINK2
      && flt_ms_ff == 12'(2 * led_pkg::BLINK_MS)) |=> fault_led_o)
      else $error("double blink second pulse missing");

   // Timebase and restart

   a_tick_at_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      tick_ff |-> tick_cnt_ff == '0)
      else $error("tick out of step with its counter");

   a_ms_restart: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (nxt_rdy_pat != rdy_pat_ff) |=> rdy_ms_ff == 12'h000)
      else $error("pattern position not restarted");

   a_ms_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (!tick_ff && nxt_rdy_pat == rdy_pat_ff) |=> $stable(rdy_ms_ff))
      else $error("pattern position moved without tick");

   // Interrupt

   a_irq_level: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (|(ev_rise & irq_mask_ff) && !(wr_en && hit_mask)) |=> irq_o)
      else $error("unmasked event raised no interrupt");
endmodule // status_led_pattern_driver

// ===== verification/lamp_viewer.sv
// Operator model for one front-panel lamp: measures lit and dark runs.
// Assumes the lamp is a registered level sampled on the system clock.
`timescale 1ns/1ps
module lamp_viewer (
   // System
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Lamp under view
   input wire logic lamp_i,
   // Length in cycles of the last complete lit and dark runs
   output int on_len_o,
   output int off_len_o
);
   int run_ff;
   logic prev_ff;
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         run_ff <= 0;
         prev_ff <= 1'h0;
         on_len_o <= 0;
         off_len_o <= 0;
      end else begin
         prev_ff <= lamp_i;
         if (lamp_i !== prev_ff) begin
            run_ff <= 1;
            if (prev_ff) on_len_o <= run_ff;
            else off_len_o <= run_ff;
         end else begin
            run_ff <= run_ff + 1;
         end
      end
   end
endmodule // lamp_viewer

// ===== verification/tb.sv
// Self-checking bench for the status lamp pattern driver.
// Assumes a zero-wait APB slave and a 10-cycle millisecond tick.
`timescale 1ns/1ps
module tb;
   localparam int TK = 10;
   localparam logic [31:0] OP = 32'h31;
   logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic ready_led_o, fault_led_o, irq_o, err;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd_d;
   int ron, roff, fon, foff, a;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   status_led_pattern_driver #(.TICK_CYC(TK)) uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .ready_led_o(ready_led_o), .fault_led_o(fault_led_o),
      .irq_o(irq_o));
   lamp_viewer rv (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .lamp_i(ready_led_o), .on_len_o(ron), .off_len_o(roff));
   lamp_viewer fv (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .lamp_i(fault_led_o), .on_len_o(fon), .off_len_o(foff));
   initial begin
      clk_sys_i = 1'h0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [31:0] b(input int i);
      return 32'h1 << i;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1'h1;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'h1;
      do @(posedge clk_sys_i); while (pready_o !== 1'h1);
      err = pslverr_o;
      rd_d = prdata_o;
      psel_i <= 1'h0;
      penable_i <= 1'h0;
   endtask
   task automatic lamps(input logic r, input logic f);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("ready lamp", ready_led_o, r);
      chk("fault lamp", fault_led_o, f);
   endtask
   task automatic pat(input logic [2:0] r, input logic [2:0] f);
      apb(led_pkg::ADDR_STAT, 1'h0, 32'h0);
      chk("ready pattern", rd_d[2:0], r);
      chk("fault pattern", rd_d[6:4], f);
   endtask
   task automatic rises(input logic f, input int n);
      logic p, c;
      p = f ? fault_led_o : ready_led_o;
      while (n > 0) begin
         @(posedge clk_sys_i);
         #1 c = f ? fault_led_o : ready_led_o;
         if (c && !p) n--;
         p = c;
      end
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic t_reset;
      chk("irq", irq_o, 1'h0);
      lamps(1'h0, 1'h0);
      apb(led_pkg::ADDR_CTRL, 1'h0, 32'h0);
      chk("ctrl reset", rd_d, led_pkg::CTRL_RST);
      apb(led_pkg::ADDR_CTRL, 1'h1, 32'h34);
      lamps(1'h0, 1'h0);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP | b(led_pkg::C_FAILED));
      lamps(1'h0, 1'h0);
      $display("test reset done");
   endtask
   int a_l[3] = '{led_pkg::C_BROKEN, led_pkg::C_NOFIELD, led_pkg::C_PDS_SHORT};
   task automatic t_flicker;
      apb(led_pkg::ADDR_CTRL, 1'h1, b(led_pkg::C_POWER) | b(led_pkg::C_ADDRESSING) | b(led_pkg::C_BROKEN));
      lamps(1'h1, 1'h0);
      rises(1'h0, 3);
      chk("flicker on", ron, 50 * TK);
      chk("flicker off", roff, 50 * TK);
      chk("fault dark", fault_led_o, 1'h0);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP);
      lamps(1'h1, 1'h0);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP | b(led_pkg::C_OVERCUR));
      lamps(1'h1, 1'h1);
      pat(led_pkg::PAT_ON, led_pkg::PAT_FLICKER);
      foreach (a_l[i]) begin
         apb(led_pkg::ADDR_CTRL, 1'h1, OP);
         apb(led_pkg::ADDR_CTRL, 1'h1, OP | b(a_l[i]));
         lamps(1'h1, 1'h1);
         pat(led_pkg::PAT_ON, led_pkg::PAT_FLICKER);
      end
      $display("test flicker done");
   endtask
   task automatic t_blink;
      apb(led_pkg::ADDR_CTRL, 1'h1, b(led_pkg::C_POWER) | b(led_pkg::C_PREOP));
      rises(1'h0, 3);
      chk("blink on", ron, 200 * TK);
      chk("blink off", roff, 200 * TK);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP | b(led_pkg::C_NONFATAL) | b(led_pkg::C_OVERCUR));
      pat(led_pkg::PAT_ON, led_pkg::PAT_FLICKER);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP);
      pat(led_pkg::PAT_ON, led_pkg::PAT_BLINK1);
      chk("nonfatal latch", rd_d[17], 1'h1);
      apb(led_pkg::ADDR_CTRL, 1'h1, 32'h0);
      lamps(1'h0, 1'h0);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP | b(led_pkg::C_BUS_STOP));
      pat(led_pkg::PAT_ON, led_pkg::PAT_BLINK2);
      rises(1'h1, 3);
      a = foff;
      rises(1'h1, 1);
      chk("double on", fon, 200 * TK);
      chk("double gaps", a + foff, (200 + led_pkg::PAUSE_MS) * TK);
      chk("double gap", a == 200 * TK || foff == 200 * TK, 1'h1);
      $display("test blink done");
   endtask
   task automatic t_wdog;
      apb(led_pkg::ADDR_CTRL, 1'h1, OP | b(led_pkg::C_WDOG) | b(led_pkg::C_OVERCUR));
      lamps(1'h1, 1'h1);
      repeat (60 * TK) @(posedge clk_sys_i);
      lamps(1'h1, 1'h1);
      chk("irq masked", irq_o, 1'h0);
      apb(led_pkg::ADDR_IRQ, 1'h0, 32'h0);
      chk("irq status", rd_d[led_pkg::I_WDOG], 1'h1);
      apb(led_pkg::ADDR_MASK, 1'h1, 32'h1);
      lamps(1'h1, 1'h1);
      chk("irq on", irq_o, 1'h1);
      apb(led_pkg::ADDR_IRQ, 1'h1, 32'hF);
      lamps(1'h1, 1'h1);
      chk("irq off", irq_o, 1'h0);
      apb(led_pkg::ADDR_CTRL, 1'h1, OP);
      lamps(1'h1, 1'h1);
      apb(8'h14, 1'h1, 32'hFFFF_FFFF);
      chk("unmapped err", err, 1'h1);
      apb(8'h14, 1'h0, 32'h0);
      chk("unmapped data", rd_d, 32'h0);
      apb(led_pkg::ADDR_CTRL, 1'h1, 32'h0);
      lamps(1'h0, 1'h0);
      $display("test watchdog done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         $display("timeout");
         close_out();
      end
   end
   initial begin
      srst_i = 1'h1;
      psel_i = 1'h0;
      penable_i = 1'h0;
      pwrite_i = 1'h0;
      paddr_i = 8'h0;
      pwdata_i = 32'h0;
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'h0;
      t_reset();
      t_flicker();
      t_blink();
      t_wdog();
      close_out();
   end
endmodule // tb
